// >>> buck_cfg_map.svh
// Register offsets, field positions, reset values and scaling constants of the buck configuration.
`ifndef BUCK_CFG_MAP_SVH
`define BUCK_CFG_MAP_SVH

`define ADDR_WIDTH            5
`define DATA_WIDTH            10

`define ADDR_NOP              5'h00
`define ADDR_PEAK_VALUE1      5'h01
`define ADDR_PEAK_VALUE2      5'h02
`define ADDR_PEAK_RANGE       5'h03
`define ADDR_OFF_TIME         5'h04
`define ADDR_CONTROL          5'h05

`define PEAK_VALUE_MSB        8
`define RANGE_LS1_LOW_BIT     7
`define RANGE_LS2_LOW_BIT     6
`define RANGE_CH1_MSB         5
`define RANGE_CH1_LSB         3
`define RANGE_CH2_MSB         2
`define RANGE_CH2_LSB         0

`define OFF_TIME_CH1_MSB      9
`define OFF_TIME_CH1_LSB      5
`define OFF_TIME_CH2_MSB      4
`define OFF_TIME_CH2_LSB      0

`define CTRL_OFFSET_DIS1_BIT  9
`define CTRL_OFFSET_DIS2_BIT  8
`define CTRL_SLOW_SLOPE_BIT   7
`define CTRL_OC_PERSIST_MSB   6
`define CTRL_OC_PERSIST_LSB   5
`define CTRL_FAILSAFE_MSB     4
`define CTRL_FAILSAFE_LSB     2
`define CTRL_CH1_ENABLE_BIT   1
`define CTRL_CH2_ENABLE_BIT   0

`define RESET_PEAK_VALUE      9'h000
`define RESET_PEAK_RANGE      8'h00
`define RESET_OFF_TIME        10'h000
`define RESET_CONTROL         10'h000

`define PEAK_BASE_OFFSET      14'h0049
`define OC_COUNT_MAX          3'h7
`define OFF_TIME_WIDTH        13

`endif

// >>> buck_cfg_pkg.sv
// Types shared by the buck configuration register bank and its off-time table.
`include "buck_cfg_map.svh"

package buck_cfg_pkg;

    typedef enum logic [2:0] {
        RANGE1 = 3'h0,
        RANGE2 = 3'h1,
        RANGE3 = 3'h2,
        RANGE4 = 3'h3,
        RANGE5 = 3'h4
    } peak_range_t;

    typedef logic [`ADDR_WIDTH-1:0]     reg_addr_t;
    typedef logic [`DATA_WIDTH-1:0]     reg_data_t;
    typedef logic [`OFF_TIME_WIDTH-1:0] off_time_t;
    typedef logic [13:0]                peak_level_t;

endpackage

// >>> off_time_rom.sv
// Two-port table of off-time times coil-voltage products, in units of 0.01 us*V.
`timescale 1ns/1ps
`default_nettype none

module off_time_rom
    import buck_cfg_pkg::*;
(
    // Clock and control
    input  wire logic       core_clk,
    input  wire logic       clkEnable,
    input  wire logic       rst,
    // Lookup ports
    input  wire logic [4:0] codeA,
    input  wire logic [4:0] codeB,
    output var  off_time_t  productA,
    output var  off_time_t  productB
);

    typedef struct packed {
        off_time_t productA;
        off_time_t productB;
    } rom_state_t;

    rom_state_t state_q;
    rom_state_t state_d;

    // Decreasing table so that the ripple current stays constant across coil voltages.
    function automatic off_time_t lookup(input logic [4:0] code);
        case (code)
            5'h00: lookup = 13'h1388;
            5'h01: lookup = 13'h1220;
            5'h02: lookup = 13'h10D6;
            5'h03: lookup = 13'h0FA0;
            5'h04: lookup = 13'h0E7E;
            5'h05: lookup = 13'h0D7A;
            5'h06: lookup = 13'h0C80;
            5'h07: lookup = 13'h0B9A;
            5'h08: lookup = 13'h0AC8;
            5'h09: lookup = 13'h0A00;
            5'h0A: lookup = 13'h094C;
            5'h0B: lookup = 13'h08A2;
            5'h0C: lookup = 13'h0802;
            5'h0D: lookup = 13'h076C;
            5'h0E: lookup = 13'h06EA;
            5'h0F: lookup = 13'h0668;
            5'h10: lookup = 13'h05F0;
            5'h11: lookup = 13'h0582;
            5'h12: lookup = 13'h051E;
            5'h13: lookup = 13'h04C4;
            5'h14: lookup = 13'h046A;
            5'h15: lookup = 13'h041A;
            5'h16: lookup = 13'h03CF;
            5'h17: lookup = 13'h0389;
            5'h18: lookup = 13'h0349;
            5'h19: lookup = 13'h030C;
            5'h1A: lookup = 13'h02D5;
            5'h1B: lookup = 13'h02A1;
            5'h1C: lookup = 13'h0271;
            5'h1D: lookup = 13'h0244;
            5'h1E: lookup = 13'h021A;
            default: lookup = 13'h01F4;
        endcase
    endfunction

    always_comb begin
        state_d          = state_q;
        state_d.productA = lookup(codeA);
        state_d.productB = lookup(codeB);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= '0;
        end else if (clkEnable) begin
            state_q <= state_d;
        end
    end

    assign productA = state_q.productA;
    assign productB = state_q.productB;

endmodule // off_time_rom

`default_nettype wire

// >>> buck_channel_config_regs.sv
// Configuration register bank for the two buck LED current regulator channels.
//
// Overview of operation
// - Channel 2 low-side pre-driver runs at low LED voltage only when its bit is set.
// - Channel 1 range codes 000 to 100 select ranges 1 to 5.
// - A written channel 1 range waits until the channel 1 peak value is written.
// - Channel 2 range codes 000 to 100 select ranges 1 to 5.
// - A written channel 2 range waits until the channel 2 peak value is written.
// - Off-time register: channel 1 code in bits 9:5, channel 2 in 4:0, reset zero.
// - Each off-time code picks a decreasing product, 50.0 down to 5.00 us*V.
// - Control register: offset disables 9 and 8, slow slope 7, persistence 6:5, etc.
// - Channel 1 comparator offset cancellation runs unless its disable bit is set.
// - Channel 2 comparator offset cancellation runs unless its disable bit is set.
// - High-side switches use slow slopes when the slope bit is set.
// - Over-current is flagged after persisting more than persistence code plus one periods.
// - Channel 1 regulator runs only while its enable bit is set.
// - The 9-bit peak value is scaled by the currently active range.
`timescale 1ns/1ps
`default_nettype none

`include "buck_cfg_map.svh"

module buck_channel_config_regs
    import buck_cfg_pkg::*;
(
    // Clock, clock enable and reset
    input  wire logic   core_clk,
    input  wire logic   clkEnable,
    input  wire logic   rst,
    // Register access port from the serial interface engine
    input  wire logic   regWrite,
    input  wire logic   regRead,
    input  wire logic [`ADDR_WIDTH-1:0] regAddr,
    input  wire logic [`DATA_WIDTH-1:0] regWrData,
    output var  logic [`DATA_WIDTH-1:0] regRdData,
    output var  logic   regRdValid,
    // Analog status levels, asynchronous to core_clk
    input  wire logic   ledVoltageLow1,
    input  wire logic   ledVoltageLow2,
    input  wire logic   overcurrentRaw1,
    input  wire logic   overcurrentRaw2,
    // Switching period ends from the regulator timing logic
    input  wire logic   switchPeriodEnd1,
    input  wire logic   switchPeriodEnd2,
    // Channel 1 controls
    output var  logic   channel1Run,
    output var  logic   lowside1PredriverOn,
    output var  logic   offsetCancel1Run,
    output var  peak_range_t activeRange1,
    output var  peak_level_t peakLevel1,
    output var  off_time_t   offTimeProduct1,
    output var  logic   overcurrentFlag1,
    // Channel 2 controls
    output var  logic   channel2Run,
    output var  logic   lowside2PredriverOn,
    output var  logic   offsetCancel2Run,
    output var  peak_range_t activeRange2,
    output var  peak_level_t peakLevel2,
    output var  off_time_t   offTimeProduct2,
    output var  logic   overcurrentFlag2,
    // Shared controls
    output var  logic   highsideSlowSlope,
    output var  logic [2:0] failsafeSelect
);

    typedef struct packed {
        logic [`PEAK_VALUE_MSB:0] peakValue1;
        logic [`PEAK_VALUE_MSB:0] peakValue2;
        logic [7:0]               rangeReg;
        logic [`DATA_WIDTH-1:0]   offTime;
        logic [`DATA_WIDTH-1:0]   control;
        peak_range_t              active1;
        peak_range_t              active2;
        peak_level_t              level1;
        peak_level_t              level2;
        logic [2:0]               ocCount1;
        logic [2:0]               ocCount2;
        logic                     ocFlag1;
        logic                     ocFlag2;
        logic                     lowside1On;
        logic                     lowside2On;
        logic [3:0]               syncStage1;
        logic [3:0]               syncStage2;
        logic [`DATA_WIDTH-1:0]   rdData;
        logic                     rdValid;
    } regs_state_t;

    regs_state_t state_q;
    regs_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////////////////////

    // Codes 101 to 111 have no defined range; they saturate at the largest one.
    function automatic peak_range_t decodeRange(input logic [2:0] code);
        case (code)
            3'h0:    decodeRange = RANGE1;
            3'h1:    decodeRange = RANGE2;
            3'h2:    decodeRange = RANGE3;
            3'h3:    decodeRange = RANGE4;
            default: decodeRange = RANGE5;
        endcase
    endfunction

    // Level in units of the range 1 step; each range doubles the step and the offset.
    function automatic peak_level_t scalePeak(input logic [`PEAK_VALUE_MSB:0] value,
                                              input peak_range_t range);
        peak_level_t base;
        base      = {5'h00, value} + `PEAK_BASE_OFFSET;
        scalePeak = base << range;
    endfunction

    // Counts switching periods with over-current present; a period without it restarts.
    function automatic logic [2:0] nextOcCount(input logic [2:0] count,
                                               input logic       periodEnd,
                                               input logic       overcurrent);
        if (!periodEnd) begin
            nextOcCount = count;
        end else if (!overcurrent) begin
            nextOcCount = 3'h0;
        end else if (count == `OC_COUNT_MAX) begin
            nextOcCount = count;
        end else begin
            nextOcCount = count + 3'h1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////

    logic [1:0] ocPersist;
    logic [2:0] ocLimit;
    logic [2:0] pendingRange1;
    logic [2:0] pendingRange2;

    assign ocPersist     = state_q.control[`CTRL_OC_PERSIST_MSB:`CTRL_OC_PERSIST_LSB];
    assign ocLimit       = {1'b0, ocPersist} + 3'h1;
    assign pendingRange1 = state_q.rangeReg[`RANGE_CH1_MSB:`RANGE_CH1_LSB];
    assign pendingRange2 = state_q.rangeReg[`RANGE_CH2_MSB:`RANGE_CH2_LSB];

    always_comb begin
        state_d = state_q;

        // Two-stage synchronisers: bit order {ledLow2, ledLow1, oc2, oc1}.
        state_d.syncStage1 = {ledVoltageLow2, ledVoltageLow1, overcurrentRaw2, overcurrentRaw1};
        state_d.syncStage2 = state_q.syncStage1;

        // Register writes; the range field only stores a pending choice.
        if (regWrite) begin
            if (regAddr == `ADDR_PEAK_VALUE1) begin
                state_d.peakValue1 = regWrData[`PEAK_VALUE_MSB:0];
                state_d.active1    = decodeRange(pendingRange1);
            end else if (regAddr == `ADDR_PEAK_VALUE2) begin
                state_d.peakValue2 = regWrData[`PEAK_VALUE_MSB:0];
                state_d.active2    = decodeRange(pendingRange2);
            end else if (regAddr == `ADDR_PEAK_RANGE) begin
                state_d.rangeReg   = regWrData[7:0];
            end else if (regAddr == `ADDR_OFF_TIME) begin
                state_d.offTime    = regWrData;
            end else if (regAddr == `ADDR_CONTROL) begin
                state_d.control    = regWrData;
            end
        end

        // Peak levels follow the stored value and the active range.
        state_d.level1 = scalePeak(state_d.peakValue1, state_d.active1);
        state_d.level2 = scalePeak(state_d.peakValue2, state_d.active2);

        // Low-side pre-drivers at low LED voltage.
        state_d.lowside1On = state_q.syncStage2[2] & state_q.rangeReg[`RANGE_LS1_LOW_BIT];
        state_d.lowside2On = state_q.syncStage2[3]
                           & state_q.rangeReg[`RANGE_LS2_LOW_BIT];

        // Over-current persistence.
        state_d.ocCount1 = nextOcCount(state_q.ocCount1, switchPeriodEnd1, state_q.syncStage2[0]);
        state_d.ocCount2 = nextOcCount(state_q.ocCount2, switchPeriodEnd2, state_q.syncStage2[1]);
        state_d.ocFlag1  = state_d.ocCount1 > ocLimit;
        state_d.ocFlag2  = state_d.ocCount2 > ocLimit;

        // Read data are registered; unmapped and no-operation addresses read zero.
        state_d.rdValid = regRead;
        if (regRead) begin
            if (regAddr == `ADDR_PEAK_VALUE1) begin
                state_d.rdData = {1'b0, state_q.peakValue1};
            end else if (regAddr == `ADDR_PEAK_VALUE2) begin
                state_d.rdData = {1'b0, state_q.peakValue2};
            end else if (regAddr == `ADDR_PEAK_RANGE) begin
                state_d.rdData = {2'h0, state_q.rangeReg};
            end else if (regAddr == `ADDR_OFF_TIME) begin
                state_d.rdData = state_q.offTime;
            end else if (regAddr == `ADDR_CONTROL) begin
                state_d.rdData = state_q.control;
            end else begin
                state_d.rdData = '0;
            end
        end
    end

    // Reset wins over the clock enable so that power-on always lands in a known state.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q          <= '0;
            state_q.rangeReg <= `RESET_PEAK_RANGE;
            state_q.offTime  <= `RESET_OFF_TIME;
            state_q.control  <= `RESET_CONTROL;
            state_q.active1  <= RANGE1;
            state_q.active2  <= RANGE1;
            state_q.level1   <= `PEAK_BASE_OFFSET;
            state_q.level2   <= `PEAK_BASE_OFFSET;
        end else if (clkEnable) begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////

    off_time_rom offTimeTable (
        .core_clk  (core_clk),
        .clkEnable (clkEnable),
        .rst       (rst),
        .codeA     (state_q.offTime[`OFF_TIME_CH1_MSB:`OFF_TIME_CH1_LSB]),
        .codeB     (state_q.offTime[`OFF_TIME_CH2_MSB:`OFF_TIME_CH2_LSB]),
        .productA  (offTimeProduct1),
        .productB  (offTimeProduct2)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////

    assign regRdData           = state_q.rdData;
    assign regRdValid          = state_q.rdValid;

    assign channel1Run         = state_q.control[`CTRL_CH1_ENABLE_BIT];
    assign channel2Run         = state_q.control[`CTRL_CH2_ENABLE_BIT];
    assign offsetCancel1Run    = ~state_q.control[`CTRL_OFFSET_DIS1_BIT];
    assign offsetCancel2Run    = ~state_q.control[`CTRL_OFFSET_DIS2_BIT];
    assign highsideSlowSlope   = state_q.control[`CTRL_SLOW_SLOPE_BIT];
    assign failsafeSelect      = state_q.control[`CTRL_FAILSAFE_MSB:`CTRL_FAILSAFE_LSB];

    assign lowside1PredriverOn = state_q.lowside1On;
    assign lowside2PredriverOn = state_q.lowside2On;
    assign activeRange1        = state_q.active1;
    assign activeRange2        = state_q.active2;
    assign peakLevel1          = state_q.level1;
    assign peakLevel2          = state_q.level2;
    assign overcurrentFlag1    = state_q.ocFlag1;
    assign overcurrentFlag2    = state_q.ocFlag2;

endmodule // buck_channel_config_regs

`default_nettype wire

// >>> buck_channel_config_regs_sva.sv
// Port-level checks of the buck configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg_map.svh"

module buck_channel_config_regs_chk
    import buck_cfg_pkg::*;
(
    // Clock and reset
    input wire logic                   core_clk,
    input wire logic                   clkEnable,
    input wire logic                   rst,
    // Register port
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [`ADDR_WIDTH-1:0] regAddr,
    input wire logic [`DATA_WIDTH-1:0] regWrData,
    input wire logic                   regRdValid,
    // Controls
    input wire logic                   ledVoltageLow2,
    input wire logic                   lowside2PredriverOn,
    input wire logic                   channel1Run,
    input wire logic                   offsetCancel2Run,
    input wire logic                   highsideSlowSlope,
    input wire logic [2:0]             failsafeSelect,
    input wire peak_range_t            activeRange1,
    input wire peak_range_t            activeRange2
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic ctlWr;
    assign ctlWr = regWrite && clkEnable && regAddr == `ADDR_CONTROL;

    ////////////////////////////////////////////////////////////////////////////////
    a_rdvalid_follows: assert property (regRead && clkEnable |=> regRdValid)
        else $error("read strobe not answered next cycle");
    a_rdvalid_cause: assert property (regRdValid |-> $past(regRead && clkEnable))
        else $error("read valid without a read");
    a_range1_pending: assert property (!$stable(activeRange1) |->
        $past(rst) || $past(regWrite && clkEnable && regAddr == `ADDR_PEAK_VALUE1))
        else $error("channel 1 range moved without a value write");
    a_range2_pending: assert property (!$stable(activeRange2) |->
        $past(rst) || $past(regWrite && clkEnable && regAddr == `ADDR_PEAK_VALUE2))
        else $error("channel 2 range moved without a value write");
    a_ch1_enable: assert property (ctlWr |=> channel1Run == $past(regWrData[1]))
        else $error("channel 1 run does not follow control");
    a_offset2_cancel: assert property (ctlWr |=> offsetCancel2Run != $past(regWrData[8]))
        else $error("channel 2 offset cancel does not follow control");
    a_slow_slope: assert property (ctlWr |=> highsideSlowSlope == $past(regWrData[7]))
        else $error("slope select does not follow control");
    a_failsafe_field: assert property (ctlWr |=> failsafeSelect == $past(regWrData[4:2]))
        else $error("failsafe select does not follow control");
    a_lowside2_gate: assert property (lowside2PredriverOn |-> $past(ledVoltageLow2, 3))
        else $error("low side 2 on without low LED voltage");
endmodule // buck_channel_config_regs_chk

bind buck_channel_config_regs buck_channel_config_regs_chk buck_channel_config_regs_chk_i (
    .core_clk(core_clk), .clkEnable(clkEnable), .rst(rst), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdValid(regRdValid),
    .ledVoltageLow2(ledVoltageLow2), .lowside2PredriverOn(lowside2PredriverOn),
    .channel1Run(channel1Run), .offsetCancel2Run(offsetCancel2Run),
    .highsideSlowSlope(highsideSlowSlope), .failsafeSelect(failsafeSelect),
    .activeRange1(activeRange1), .activeRange2(activeRange2));
`default_nettype wire

// >>> reg_host_model.sv
// Host model that issues register writes and reads toward the device.
`timescale 1ns/1ps
`default_nettype none

module reg_host_model
    import buck_cfg_pkg::*;
(
    // Clock
    input  wire logic core_clk,
    // Register port toward the device
    output var  logic      regWrite,
    output var  logic      regRead,
    output var  reg_addr_t regAddr,
    output var  reg_data_t regWrData
);
    initial begin
        regWrite = 1'h0;
        regRead = 1'h0;
        regAddr = 5'h00;
        regWrData = 10'h000;
    end

    // Callers write a range before its value, so the new range lands with the value.
    task automatic write(input reg_addr_t a, input reg_data_t d);
        @(posedge core_clk);
        #1;
        regWrite = 1'h1;
        regAddr = a;
        regWrData = d;
        @(posedge core_clk);
        #1;
        regWrite = 1'h0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    task automatic read(input reg_addr_t a);
        @(posedge core_clk);
        #1;
        regRead = 1'h1;
        regAddr = a;
        @(posedge core_clk);
        #1;
        regRead = 1'h0;
        regAddr = ~a;
    endtask
endmodule // reg_host_model
`default_nettype wire

// >>> buck_channel_config_regs_bench.sv
// Self-checking bench of the buck configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`include "buck_cfg_map.svh"

module buck_channel_config_regs_bench;
    import buck_cfg_pkg::*;
    logic core_clk, clkEnable, rst, regWrite, regRead, regRdValid, ledLow, ocRaw, periodEnd;
    logic run1, run2, ls1, ls2, cancel1, cancel2, oc1, oc2, slope;
    reg_addr_t regAddr;
    reg_data_t regWrData, regRdData, d, masks[7];
    peak_range_t range1, range2;
    peak_level_t level1, level2;
    off_time_t toff1, toff2;
    logic [2:0] fsel, prev, rc;
    logic [8:0] v;
    logic [31:0] seed = 32'h1;
    int fails, comparisons;
    reg_data_t expQ[$];

    buck_channel_config_regs buck_channel_config_regs_i (
        .core_clk(core_clk), .clkEnable(clkEnable), .rst(rst), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .ledVoltageLow1(ledLow), .ledVoltageLow2(ledLow),
        .overcurrentRaw1(ocRaw), .overcurrentRaw2(ocRaw), .switchPeriodEnd1(periodEnd),
        .switchPeriodEnd2(periodEnd), .channel1Run(run1), .lowside1PredriverOn(ls1),
        .offsetCancel1Run(cancel1), .activeRange1(range1), .peakLevel1(level1),
        .offTimeProduct1(toff1), .overcurrentFlag1(oc1), .channel2Run(run2),
        .lowside2PredriverOn(ls2), .offsetCancel2Run(cancel2), .activeRange2(range2),
        .peakLevel2(level2), .offTimeProduct2(toff2), .overcurrentFlag2(oc2),
        .highsideSlowSlope(slope), .failsafeSelect(fsel));
    reg_host_model reg_host_model_i (.core_clk(core_clk), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse();
        cyc(1);
        periodEnd = 1'h1;
        cyc(1);
        periodEnd = 1'h0;
    endtask

    task automatic rd(input reg_addr_t a, input reg_data_t e);
        expQ.push_back(e);
        reg_host_model_i.read(a);
    endtask

    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Reads are answered one cycle late; sampling on the falling edge avoids racing the flop.
    always @(negedge core_clk) begin
        if (regRdValid === 1'h1) begin
            chk("read data", expQ.size() > 0 ? 14'(expQ.pop_front()) : 14'h3FFF, 14'(regRdData));
        end
    end

    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        cyc(5000);
        fails++;
        $display("wrong value run length expected finish seen timeout");
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        masks = '{10'h000, 10'h1FF, 10'h1FF, 10'h0FF, 10'h3FF, 10'h3FF, 10'h000};
        {clkEnable, rst, ledLow, ocRaw, periodEnd} = 5'h18;
        cyc(3);
        rst = 1'h0;
        rd(`ADDR_OFF_TIME, 10'h000);
        rd(`ADDR_CONTROL, 10'h000);
        chk("cancel1 reset", 14'h1, 14'(cancel1));
        for (int i = 0; i < 7; i++) begin
            d = 10'(rnd());
            reg_host_model_i.write(5'(i), d);
            rd(5'(i), d & masks[i]);
        end
        $display("test readback done");
        prev = 3'h0;
        for (int c = 0; c < 8; c++) begin
            v = 9'(rnd());
            rc = (c > 4) ? 3'h4 : 3'(c);
            reg_host_model_i.write(`ADDR_PEAK_RANGE, {4'h0, c[2:0], c[2:0]});
            chk("range1 held", 14'(prev), 14'(range1));
            reg_host_model_i.write(`ADDR_PEAK_VALUE1, {1'h0, v});
            chk("range1", 14'(rc), 14'(range1));
            chk("level1", (14'(v) + `PEAK_BASE_OFFSET) << rc, level1);
            chk("range2 held", 14'(prev), 14'(range2));
            reg_host_model_i.write(`ADDR_PEAK_VALUE2, {1'h0, v});
            chk("range2", 14'(rc), 14'(range2));
            chk("level2", (14'(v) + `PEAK_BASE_OFFSET) << rc, level2);
            prev = rc;
        end
        $display("test ranges done");
        for (int k = 0; k < 32; k += 31) begin
            reg_host_model_i.write(`ADDR_OFF_TIME, {5'(k), 5'(31 - k)});
            cyc(1);
            chk("off time1", k > 0 ? 14'h01F4 : 14'h1388, 14'(toff1));
            chk("off time2", k > 0 ? 14'h1388 : 14'h01F4, 14'(toff2));
        end
        for (int i = 0; i < 4; i++) begin
            d = i[0] ? ~d : 10'(rnd());
            reg_host_model_i.write(`ADDR_CONTROL, d);
            chk("run1", 14'(d[1]), 14'(run1));
            chk("run2", 14'(d[0]), 14'(run2));
            chk("cancel1", 14'(!d[9]), 14'(cancel1));
            chk("cancel2", 14'(!d[8]), 14'(cancel2));
            chk("slope", 14'(d[7]), 14'(slope));
            chk("failsafe", 14'(d[4:2]), 14'(fsel));
        end
        $display("test control done");
        ledLow = 1'h1;
        for (int k = 0; k < 4; k++) begin
            reg_host_model_i.write(`ADDR_PEAK_RANGE, {2'h0, k[1], k[0], 6'h00});
            cyc(4);
            chk("low side1", 14'(k[1]), 14'(ls1));
            chk("low side2", 14'(k[0]), 14'(ls2));
        end
        ledLow = 1'h0;
        cyc(4);
        chk("low side2 off", 14'h0, 14'(ls2));
        $display("test low side done");
        for (int c = 0; c < 4; c++) begin
            reg_host_model_i.write(`ADDR_CONTROL, 10'(c << 5));
            ocRaw = 1'h0;
            cyc(3);
            pulse();
            ocRaw = 1'h1;
            cyc(3);
            repeat (c + 1) pulse();
            chk("oc early", 14'h0, 14'({oc1, oc2}));
            pulse();
            chk("oc flags", 14'h3, 14'({oc1, oc2}));
        end
        $display("test overcurrent done");
        clkEnable = 1'h0;
        reg_host_model_i.write(`ADDR_OFF_TIME, 10'h155);
        clkEnable = 1'h1;
        rd(`ADDR_OFF_TIME, 10'h3E0);
        cyc(3);
        chk("reads left", 14'h0, 14'(expQ.size()));
        $display("test clock enable done");
        conclude();
    end
endmodule // buck_channel_config_regs_bench
`default_nettype wire
